/* line_driver_enable_cfg.svh */
`ifndef LINE_DRIVER_ENABLE_CFG_SVH
`define LINE_DRIVER_ENABLE_CFG_SVH

`define CHANNELS 12
`define CH_PER_REG 6
`define OFF_TX_LOW 8'h00
`define OFF_RX_LOW 8'h08
`define OFF_TX_HIGH 8'h80
`define OFF_RX_HIGH 8'h88
`define ENABLE_FIELD_MSB 5
`define REG_RESET 6'h00

`endif

/* line_driver_enable_pkg.sv */
package line_driver_enable_pkg;
   typedef struct packed {
      logic [7:0] adr;
      logic we;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic [11:0] out;
      logic [11:0] oe_n;
   } line_pin_t;
endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Three stages, change accepted when last two agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q_o <= 1'b0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_o <= s3_reg;
         end
      end
   end
endmodule // pin_sync

/* line_driver_enable_regs.sv */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "line_driver_enable_cfg.svh"
module line_driver_enable_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic transmit_section_on_i,
   input wire logic [11:0] tx_data_pos_i,
   input wire logic [11:0] tx_data_neg_i,
   output logic [11:0] tx_line_pos_pin_o,
   output logic [11:0] tx_line_neg_pin_o,
   output logic [11:0] tx_line_oe_n_o,
   output logic [11:0] rx_line_term_oe_n_o,
   output logic [11:0] receive_section_on_o
);
   logic [5:0] tx_low_reg;
   logic [5:0] rx_low_reg;
   logic [5:0] tx_high_reg;
   logic [5:0] rx_high_reg;
   logic master_on;
   logic [11:0] tx_enable;
   logic [11:0] rx_enable;
   logic req;
   logic wr;
   logic [5:0] rdata;
   logic [5:0] wr_field;
   logic hit_tx_low;
   logic hit_rx_low;
   logic hit_tx_high;
   logic hit_rx_high;
   line_driver_enable_pkg::wb_req_t bus_req;
   line_driver_enable_pkg::line_pin_t tx_pos_next;
   line_driver_enable_pkg::line_pin_t tx_neg_next;
   line_driver_enable_pkg::line_pin_t rx_next;

   pin_sync pin_sync_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(transmit_section_on_i),
      .q_o(master_on)
   );

   // Bus request carrier
   always_comb begin
      bus_req.adr = adr_i;
      bus_req.we = we_i;
      bus_req.sel = sel_i;
      bus_req.dat = dat_i;
   end

   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && bus_req.we && bus_req.sel[0];
   assign wr_field = bus_req.dat[`ENABLE_FIELD_MSB:0];

   always_comb begin
      hit_tx_low = 1'b0;
      hit_rx_low = 1'b0;
      hit_tx_high = 1'b0;
      hit_rx_high = 1'b0;
      if (bus_req.adr == `OFF_TX_LOW) begin
         hit_tx_low = 1'b1;
      end else if (bus_req.adr == `OFF_RX_LOW) begin
         hit_rx_low = 1'b1;
      end else if (bus_req.adr == `OFF_TX_HIGH) begin
         hit_tx_high = 1'b1;
      end else if (bus_req.adr == `OFF_RX_HIGH) begin
         hit_rx_high = 1'b1;
      end
   end

   // One-cycle ack per request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_low_reg <= `REG_RESET;
      end else if (wr && hit_tx_low) begin
         tx_low_reg <= wr_field;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_low_reg <= `REG_RESET;
      end else if (wr && hit_rx_low) begin
         rx_low_reg <= wr_field;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_high_reg <= `REG_RESET;
      end else if (wr && hit_tx_high) begin
         tx_high_reg <= wr_field;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_high_reg <= `REG_RESET;
      end else if (wr && hit_rx_high) begin
         rx_high_reg <= wr_field;
      end
   end

   always_comb begin
      if (hit_tx_low) begin
         rdata = tx_low_reg;
      end else if (hit_rx_low) begin
         rdata = rx_low_reg;
      end else if (hit_tx_high) begin
         rdata = tx_high_reg;
      end else if (hit_rx_high) begin
         rdata = rx_high_reg;
      end else begin
         rdata = 6'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (req && !bus_req.we) begin
         dat_o <= {26'h0000000, rdata};
      end
   end

   assign tx_enable = {tx_high_reg, tx_low_reg} & {12{master_on}};
   assign rx_enable = {rx_high_reg, rx_low_reg};

   always_comb begin
      tx_pos_next.out = tx_data_pos_i & tx_enable;
      tx_pos_next.oe_n = ~tx_enable;
      tx_neg_next.out = tx_data_neg_i & tx_enable;
      tx_neg_next.oe_n = ~tx_enable;
   end

   always_comb begin
      rx_next.out = rx_enable;
      rx_next.oe_n = ~rx_enable;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_line_pos_pin_o <= 12'h000;
      end else begin
         tx_line_pos_pin_o <= tx_pos_next.out;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_line_neg_pin_o <= 12'h000;
      end else begin
         tx_line_neg_pin_o <= tx_neg_next.out;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_line_oe_n_o <= 12'hfff;
      end else begin
         tx_line_oe_n_o <= tx_pos_next.oe_n & tx_neg_next.oe_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         receive_section_on_o <= 12'h000;
      end else begin
         receive_section_on_o <= rx_next.out;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_line_term_oe_n_o <= 12'hfff;
      end else begin
         rx_line_term_oe_n_o <= rx_next.oe_n;
      end
   end
endmodule // line_driver_enable_regs

/* line_driver_enable_regs_checker.sv */
`timescale 1ns/1ps
module line_driver_enable_regs_checker (
   input wire logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, transmit_section_on_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i, dat_o,
   input wire logic [11:0] tx_line_oe_n_o, rx_line_term_oe_n_o, receive_section_on_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire tk = cyc_i & stb_i & !ack_o, wt = tk & we_i & sel_i[0];
   wire [5:0] d6 = dat_i[5:0];
   property p_ack; tk |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack");
   property p_rsv; dat_o[31:6] == 26'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_rdz; tk && !we_i && adr_i == 8'h10 |=> dat_o == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("rdz");
   property p_rx0;
      wt && adr_i==8'h08 |=> ##1 receive_section_on_o[5:0] == $past(d6, 2);
   endproperty
   a_rx0: assert property (p_rx0) else $error("rx0");
   property p_rx1;
      wt && adr_i==8'h88 |=> ##1 receive_section_on_o[11:6] == $past(d6, 2);
   endproperty
   a_rx1: assert property (p_rx1) else $error("rx1");
   property p_tx1;
      wt && adr_i==8'h80 |=> ##1 (tx_line_oe_n_o[11:6] | $past(d6, 2)) == 6'h3f;
   endproperty
   a_tx1: assert property (p_tx1) else $error("tx1");
   property p_rxz; rx_line_term_oe_n_o == ~receive_section_on_o; endproperty
   a_rxz: assert property (p_rxz) else $error("rxz");
   property p_mst; !transmit_section_on_i [*6] |=> &tx_line_oe_n_o; endproperty
   a_mst: assert property (p_mst) else $error("mst");
   cover property (wt);
   cover property (tk && !we_i);
   cover property ($fell(transmit_section_on_i));
endmodule // line_driver_enable_regs_checker
bind line_driver_enable_regs line_driver_enable_regs_checker checker_inst (.*);

/* host_model.sv */
`timescale 1ns/1ps
module host_model (input wire logic clk_i, ack_i, input wire logic [31:0] dat_i,
   output line_driver_enable_pkg::wb_req_t rq_o = '0, output logic cyc_o = 0);
   task automatic xfer(input line_driver_enable_pkg::wb_req_t r, output logic [31:0] d);
      rq_o <= r;
      cyc_o <= 1'b1;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      d = dat_i;
      cyc_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule // host_model

/* tb_line_driver_enable_regs.sv */
`timescale 1ns/1ps
module tb_line_driver_enable_regs;
   logic clk_i = 0, rst_i = 1, transmit_section_on_i = 1, ack_o, cyc;
   logic [11:0] tx_data_pos_i = 0, tx_line_pos_pin_o, tx_line_neg_pin_o, tx_line_oe_n_o;
   logic [11:0] rx_line_term_oe_n_o, receive_section_on_o;
   logic [31:0] dat_o, d, s = 32'h5012, exp_q [$];
   logic [7:0] rg [4], ad [4] = '{8'h00, 8'h08, 8'h80, 8'h88};
   line_driver_enable_pkg::wb_req_t rq;
   int num_errors = 0, n_tests = 0;
   always #50 clk_i = ~clk_i;
   line_driver_enable_regs line_driver_enable_regs_inst (.adr_i(rq.adr), .dat_i(rq.dat),
      .we_i(rq.we), .sel_i(rq.sel), .cyc_i(cyc), .stb_i(cyc), .tx_data_neg_i(~tx_data_pos_i),
      .*);
   host_model host_model_inst (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .rq_o(rq), .cyc_o(cyc));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(string nm, logic [31:0] e, v);
      n_tests++;
      num_errors += (v !== e);
      if (v !== e) $display("[ERR] %s exp %h got %h", nm, e, v);
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic bus(logic [7:0] a, logic w, logic [3:0] se, logic [5:0] e);
      if (!w) exp_q.push_back({26'h0, e});
      host_model_inst.xfer('{a, w, se, s}, d);
   endtask
   always @(posedge clk_i) if (ack_o === 1'b1 && rq.we === 1'b0)
      chk("rd", exp_q.pop_front(), dat_o);
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      foreach (ad[i]) begin
         bus(ad[i], 1'b0, 4'h1, 6'h00);
         s = xs(s);
         rg[i] = {2'h0, s[5:0]};
         bus(ad[i], 1'b1, 4'h1, 6'h00);
         bus(ad[i], 1'b0, 4'h1, rg[i][5:0]);
      end
      bus(ad[0], 1'b1, 4'h0, 6'h00);
      bus(ad[0], 1'b0, 4'h1, rg[0][5:0]);
      bus(8'h10, 1'b0, 4'h1, 6'h00);
      tx_data_pos_i <= s[11:0];
      repeat (2) @(posedge clk_i);
      chk("oe", {~rg[2][5:0], ~rg[0][5:0]}, tx_line_oe_n_o);
      chk("pos", tx_data_pos_i & {rg[2][5:0], rg[0][5:0]}, tx_line_pos_pin_o);
      chk("neg", ~tx_data_pos_i & {rg[2][5:0], rg[0][5:0]}, tx_line_neg_pin_o);
      chk("rx", {rg[3][5:0], rg[1][5:0]}, receive_section_on_o);
      chk("term", {~rg[3][5:0], ~rg[1][5:0]}, rx_line_term_oe_n_o);
      transmit_section_on_i <= 0;
      repeat (8) @(posedge clk_i);
      chk("off", 12'hfff, tx_line_oe_n_o);
      chk("pos off", 12'h000, tx_line_pos_pin_o);
      chk("neg off", 12'h000, tx_line_neg_pin_o);
      test_done;
   end
   initial begin
      repeat (500) @(posedge clk_i);
      num_errors++;
      test_done;
   end
endmodule // tb_line_driver_enable_regs
